//--- rtl/power_status_irq_hard_reset.sv
// Operation
// - Held and live power-good status copies
// - Status bits map bucks then linear regulators
// - Pin mask defaults pass, zero blocks pin
// - Pin mask never hides status bits
// - Faults and persistent power-good latch interrupt
// - Clear command or 50ms button releases interrupt
// - Interrupt status bit assignment fixed
// - Interrupt mask defaults pass, one blocks
// - Masked sources still set status bits
// - Masked faults still drive state controller
// - Clear access clears latched status bits
// - Hard reset keeps interrupt state intact
// - Reset out low on undervolt or hard reset timer
// - Button hold or command starts hard reset
// - Control bit six selects 10s or 5s
// - Hard reset restores command register defaults
// - Hard reset: one-second timer, then full reset
// - Fault: one-second timer, then standby
// - Power-down sequence runs in that second
// - Enable pin and bit enable termination pair
// - Auxiliary regulator control fields
// - Serial supply loss restores command register defaults
// - Power-good error over 20ms sets bit two
module power_status_irq_hard_reset
  import pwr_status_pkg::*;
#(
  parameter longint PG_HOLD_CYCLES    = PG_HOLD_CYC,
  parameter longint PG_PERSIST_CYCLES = PG_PERSIST_CYC,
  parameter longint BUTTON_CLR_CYCLES = BUTTON_CLR_CYC,
  parameter longint STATE_CYCLES      = STATE_TIMER_CYC,
  parameter longint HR_LONG_CYCLES    = HR_LONG_CYC,
  parameter longint HR_SHORT_CYCLES   = HR_SHORT_CYC
)
(
  input  wire logic        ref_clk_in,              // 125 MHz clock
  input  wire logic        reset_n_in,              // Async reset, active low
  input  wire reg_req_t    reg_req_in,              // Decoded register access
  output logic [7:0]       reg_rdata_out,           // Read data, registered
  input  wire logic [7:0]  pg_low_in,               // Per-regulator output low
  input  wire logic [7:0]  reg_enabled_in,          // Per-regulator enabled
  input  wire fault_in_t   fault_in,                // Supply and thermal flags
  input  wire logic        button_n_in,             // Pushbutton, low active
  input  wire logic        always_alive_low_in,     // Always-alive 8% low
  input  wire logic        serial_supply_low_in,    // Serial supply under 1V
  input  wire logic        step_down1_enable_pin_in, // Step-down 1 enable pin
  input  wire logic        seq_done_in,             // Power-down sequence done
  output logic             irq_n_out,               // Interrupt, low active
  output logic             power_ok_pin_oe_out,     // Drive power-ok pin low
  output logic             reset_out_n,             // Reset output, low active
  output logic             run_seq_down_out,        // Execute power-down sequence
  output logic             term_ref_en_out,         // Termination ref enable
  output logic             step_down1_en_out,       // Step-down 1 enable
  output logic [7:0]       aux_regulator_control_out, // Auxiliary regulator fields
  output logic [1:0]       state_out                // 0 run, 1 timer, 2 full, 3 stby
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ctrl_state_t  state;
    logic [31:0]  state_cnt;
    logic [31:0]  button_cnt;
    logic [31:0]  hr_cnt;
    logic         hr_fired;
    logic [7:0]   held_status;
    logic [7:0]   live_status;
    logic [7:0]   pg_mask;
    logic [7:0]   irq_status;
    logic [7:0]   irq_mask;
    logic [7:0]   aux_ctrl;
    logic [7:0]   control;
    logic [7:0]   step_down1;
    logic [7:0]   rdata;
    logic         irq_latched;
    // Counters sized for the full-length timers
    logic [7:0][20:0] hold_cnt;
    logic [7:0][21:0] persist_cnt;
    logic [7:0]   persist_done;
  } core_t;

  // Whole module state in one struct
  core_t core_reg;
  core_t core_next;

  // Count compare helper
  // Counters start at zero, so lim - 1 is the last count
  function automatic logic reached(input logic [31:0] cnt, input longint lim);
    reached = (longint'(cnt) >= lim - 1);
  endfunction : reached

  // Per-cycle decode and event strobes
  logic clr_access;
  logic hr_cmd;
  logic hr_hold_lim_hit;
  logic [7:0] irq_set;
  logic [7:0] persist_new;
  logic button_clear;
  logic cmd_defaults;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    // Every field holds unless set below
    core_next = core_reg;
    // Any read or write of the clear command counts
    clr_access = (reg_req_in.wr_strobe || reg_req_in.rd_strobe) &&
                 (reg_req_in.addr == REG_CLEAR_IRQ);
    hr_cmd = reg_req_in.wr_strobe && (reg_req_in.addr == REG_HARD_RESET);
    // Strobes last one cycle
    persist_new = 8'h00;
    irq_set = 8'h00;

    for (int i = 0; i < 8; i++)
    begin
      core_next.live_status[i] = ~pg_low_in[i];
      // Any low cycle restarts the hold time
      if (pg_low_in[i])
      begin
        core_next.held_status[i] = 1'b0;
        core_next.hold_cnt[i] = 21'h000000;
      end
      else if (!core_reg.held_status[i])
      begin
        if (longint'(core_reg.hold_cnt[i]) >= PG_HOLD_CYCLES - 1)
          core_next.held_status[i] = 1'b1;
        else
          core_next.hold_cnt[i] = core_reg.hold_cnt[i] + 21'h000001;
      end
      // Disabled regulators never count as a fault
      // persistence filter
      if (pg_low_in[i] && reg_enabled_in[i])
      begin
        // Event strobes once per fault episode
        if (longint'(core_reg.persist_cnt[i]) >= PG_PERSIST_CYCLES)
        begin
          core_next.persist_done[i] = 1'b1;
          persist_new[i] = ~core_reg.persist_done[i];
        end
        else
          core_next.persist_cnt[i] = core_reg.persist_cnt[i] + 22'h000001;
      end
      else
      begin
        core_next.persist_cnt[i] = 22'h000000;
        core_next.persist_done[i] = 1'b0;
      end
    end

    // Button low timers
    // Counter saturates, so the release strobes
    // only once per press
    button_clear = 1'b0;
    if (!button_n_in)
    begin
      if (!reached(core_reg.button_cnt, BUTTON_CLR_CYCLES))
        core_next.button_cnt = core_reg.button_cnt + 32'h00000001;
      button_clear = reached(core_reg.button_cnt, BUTTON_CLR_CYCLES) &&
                     !reached(core_reg.button_cnt, BUTTON_CLR_CYCLES + 1);
      if (longint'(core_reg.button_cnt) == BUTTON_CLR_CYCLES - 1)
        core_next.button_cnt = core_reg.button_cnt + 32'h00000001;
    end
    else
      core_next.button_cnt = 32'h00000000;

    // hold time select
    // Fired flag stops a second hard reset per press
    hr_hold_lim_hit = 1'b0;
    if (!button_n_in && !core_reg.hr_fired)
    begin
      core_next.hr_cnt = core_reg.hr_cnt + 32'h00000001;
      if (core_reg.control[CTRL_BIT_HR_TIME])
        hr_hold_lim_hit = reached(core_reg.hr_cnt, HR_SHORT_CYCLES);
      else
        hr_hold_lim_hit = reached(core_reg.hr_cnt, HR_LONG_CYCLES);
      if (hr_hold_lim_hit)
        core_next.hr_fired = 1'b1;
    end
    else if (button_n_in)
    begin
      core_next.hr_cnt = 32'h00000000;
      core_next.hr_fired = 1'b0;
    end

    // Faults are levels; each high cycle sets again
    // status bit sources
    irq_set[IRQ_BIT_PG_TMO]  = |persist_new;
    irq_set[IRQ_BIT_UV_WARN] = fault_in.uv_warn;
    irq_set[IRQ_BIT_UV_STBY] = fault_in.uv_fault;
    irq_set[IRQ_BIT_OT_WARN] = fault_in.ot_warn;
    irq_set[IRQ_BIT_OT_STBY] = fault_in.ot_fault;
    irq_set[IRQ_BIT_HARD_RST] = (hr_cmd || hr_hold_lim_hit) &&
                                (core_reg.state == ST_RUN);

    if (clr_access || button_clear)
      core_next.irq_status[6:1] = irq_set[6:1];
    else
      core_next.irq_status[6:1] = core_reg.irq_status[6:1] | irq_set[6:1];
    // Bit 0 follows the button live, bit 7 unused
    core_next.irq_status[IRQ_BIT_BUTTON] = ~button_n_in;
    core_next.irq_status[7] = 1'b0;

    // Hard reset bit has no mask and never pulls the pin
    // latch interrupt
    if (clr_access || button_clear)
      core_next.irq_latched = |(irq_set & ~core_reg.irq_mask & IRQ_PIN_MASK_VALID);
    else
      core_next.irq_latched = core_reg.irq_latched |
                              |(irq_set & ~core_reg.irq_mask & IRQ_PIN_MASK_VALID);

    // Register writes
    // Unmapped and read-only addresses are ignored
    if (reg_req_in.wr_strobe)
    begin
      if (reg_req_in.addr == REG_PG_PIN_MASK)
        core_next.pg_mask = reg_req_in.wdata & PG_PIN_MASK_VALID;
      else if (reg_req_in.addr == REG_IRQ_PIN_MASK)
        core_next.irq_mask = reg_req_in.wdata & IRQ_PIN_MASK_VALID;
      else if (reg_req_in.addr == REG_AUX_CONTROL)
        core_next.aux_ctrl = reg_req_in.wdata & AUX_CONTROL_VALID;
      else if (reg_req_in.addr == REG_CONTROL)
        core_next.control = reg_req_in.wdata;
      else if (reg_req_in.addr == REG_STEP_DOWN1)
        core_next.step_down1 = reg_req_in.wdata;
    end

    // Read mux, unmapped reads zero
    // Data follows the address of the previous cycle
    if (reg_req_in.addr == REG_HELD_STATUS)
      core_next.rdata = core_reg.held_status;
    else if (reg_req_in.addr == REG_LIVE_STATUS)
      core_next.rdata = core_reg.live_status;
    else if (reg_req_in.addr == REG_PG_PIN_MASK)
      core_next.rdata = core_reg.pg_mask;
    else if (reg_req_in.addr == REG_IRQ_STATUS)
      core_next.rdata = core_reg.irq_status;
    else if (reg_req_in.addr == REG_IRQ_PIN_MASK)
      core_next.rdata = core_reg.irq_mask;
    else if (reg_req_in.addr == REG_AUX_CONTROL)
      core_next.rdata = core_reg.aux_ctrl;
    else if (reg_req_in.addr == REG_CONTROL)
      core_next.rdata = core_reg.control;
    else if (reg_req_in.addr == REG_STEP_DOWN1)
      core_next.rdata = core_reg.step_down1;
    else
      core_next.rdata = 8'h00;

    // State controller
    // Hard reset wins over a fault in the same cycle
    // faults act despite mask
    cmd_defaults = 1'b0;
    case (core_reg.state)
      ST_RUN:
      begin
        core_next.state_cnt = 32'h00000000;
        if (hr_cmd || hr_hold_lim_hit)
          core_next.state = ST_HR_TIMER;
        else if (fault_in.uv_fault || fault_in.ot_fault)
          core_next.state = ST_SB_TIMER;
      end
      ST_HR_TIMER:
      begin
        core_next.state_cnt = core_reg.state_cnt + 32'h00000001;
        if (reached(core_reg.state_cnt, STATE_CYCLES))
          core_next.state = ST_FULL_RST;
      end
      ST_SB_TIMER:
      begin
        core_next.state_cnt = core_reg.state_cnt + 32'h00000001;
        if (reached(core_reg.state_cnt, STATE_CYCLES))
          core_next.state = ST_STANDBY;
      end
      ST_FULL_RST:
      begin
        // Run again only after the button is released
        core_next.state_cnt = 32'h00000000;
        if (button_n_in)
          core_next.state = ST_RUN;
      end
      ST_STANDBY:
      begin
        // Leave standby once both faults are gone
        core_next.state_cnt = 32'h00000000;
        if (!fault_in.uv_fault && !fault_in.ot_fault)
          core_next.state = ST_RUN;
      end
      default:
        core_next.state = ST_RUN;
    endcase

    cmd_defaults = (core_reg.state == ST_FULL_RST) || serial_supply_low_in;
    // Software mode drops so the pins rule at next power-on
    if (core_reg.state == ST_SB_TIMER)
      core_next.control[CTRL_BIT_SW_MODE] = 1'b0;
    if (cmd_defaults)
    begin
      core_next.pg_mask    = PG_PIN_MASK_RST;
      core_next.irq_mask   = IRQ_PIN_MASK_RST;
      core_next.aux_ctrl   = AUX_CONTROL_RST;
      core_next.control    = CONTROL_RST;
      core_next.step_down1 = STEP_DOWN1_RST;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      core_reg <= '0;
      core_reg.state <= ST_RUN;
      // Status copies come up as all good
      core_reg.held_status <= 8'hff;
      core_reg.live_status <= 8'hff;
      core_reg.pg_mask <= PG_PIN_MASK_RST;
      core_reg.irq_mask <= IRQ_PIN_MASK_RST;
      core_reg.aux_ctrl <= AUX_CONTROL_RST;
      core_reg.control <= CONTROL_RST;
      core_reg.step_down1 <= STEP_DOWN1_RST;
    end
    else
      core_reg <= core_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_out = core_reg.rdata;
  // Interrupt pin low while the latch is set
  assign irq_n_out = ~core_reg.irq_latched;
  // Pulled on a passed low status or with nothing enabled
  // pass on one
  assign power_ok_pin_oe_out = |(~core_reg.held_status & core_reg.pg_mask &
                                 PG_PIN_MASK_VALID) || ~|reg_enabled_in;
  assign reset_out_n = ~(always_alive_low_in || (core_reg.state == ST_HR_TIMER));
  assign run_seq_down_out = (core_reg.state == ST_SB_TIMER) && !seq_done_in;
  assign step_down1_en_out = step_down1_enable_pin_in || core_reg.step_down1[SD1_BIT_ENABLE];
  // Termination reference shares the step-down enable
  assign term_ref_en_out = step_down1_en_out;
  assign aux_regulator_control_out = core_reg.aux_ctrl;
  // Both timer states report as one code
  assign state_out = (core_reg.state == ST_RUN) ? 2'd0 :
                     (core_reg.state == ST_FULL_RST) ? 2'd2 :
                     (core_reg.state == ST_STANDBY) ? 2'd3 : 2'd1;

endmodule : power_status_irq_hard_reset

//--- rtl/pwr_status_pkg.sv
package pwr_status_pkg;

  // ****************************************
  // Register map and field layout
  // ****************************************
  // Register indices (sub-addresses), a free choice for the block
  localparam logic [7:0] REG_HELD_STATUS   = 8'h10;
  localparam logic [7:0] REG_LIVE_STATUS   = 8'h11;
  localparam logic [7:0] REG_PG_PIN_MASK   = 8'h12;
  localparam logic [7:0] REG_IRQ_STATUS    = 8'h13;
  localparam logic [7:0] REG_IRQ_PIN_MASK  = 8'h14;
  localparam logic [7:0] REG_AUX_CONTROL   = 8'h15;
  localparam logic [7:0] REG_CONTROL       = 8'h16;
  localparam logic [7:0] REG_STEP_DOWN1    = 8'h17;
  localparam logic [7:0] REG_CLEAR_IRQ     = 8'h18;
  localparam logic [7:0] REG_HARD_RESET    = 8'h19;

  // Reset values and valid-bit masks
  localparam logic [7:0] PG_PIN_MASK_RST   = 8'hef;
  localparam logic [7:0] PG_PIN_MASK_VALID = 8'hef;
  localparam logic [7:0] IRQ_PIN_MASK_RST  = 8'h00;
  localparam logic [7:0] IRQ_PIN_MASK_VALID = 8'h7d;
  localparam logic [7:0] AUX_CONTROL_RST   = 8'h00;
  localparam logic [7:0] AUX_CONTROL_VALID = 8'h1f;
  localparam logic [7:0] CONTROL_RST       = 8'h00;
  localparam logic [7:0] STEP_DOWN1_RST    = 8'h00;

  // Field positions
  localparam int IRQ_BIT_BUTTON   = 0;
  localparam int IRQ_BIT_HARD_RST = 1;
  localparam int IRQ_BIT_PG_TMO   = 2;
  localparam int IRQ_BIT_UV_WARN  = 3;
  localparam int IRQ_BIT_UV_STBY  = 4;
  localparam int IRQ_BIT_OT_WARN  = 5;
  localparam int IRQ_BIT_OT_STBY  = 6;
  localparam int CTRL_BIT_HR_TIME = 6;
  localparam int CTRL_BIT_SW_MODE = 5;
  localparam int SD1_BIT_ENABLE   = 7;
  localparam int AUX_BIT_KEEP     = 0;
  localparam int AUX_BIT_SOFT     = 1;
  localparam int AUX_BIT_ENABLE   = 2;
  localparam int AUX_VSEL_LO      = 3;
  localparam int ALWAYS_ALIVE_IDX = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint CLK_HZ         = 125000000;
  localparam longint PG_HOLD_US     = 1000;
  localparam longint PG_PERSIST_US  = 20000;
  localparam longint BUTTON_CLR_US  = 50000;
  localparam longint STATE_TIMER_US = 1000000;
  localparam longint HR_LONG_S      = 10;
  localparam longint HR_SHORT_S     = 5;
  // Holds are least times: round up
  localparam longint PG_HOLD_CYC    = (PG_HOLD_US * CLK_HZ + 999999) / 1000000;
  localparam longint PG_PERSIST_CYC = (PG_PERSIST_US * CLK_HZ + 999999) / 1000000;
  localparam longint BUTTON_CLR_CYC = (BUTTON_CLR_US * CLK_HZ + 999999) / 1000000;
  localparam longint STATE_TIMER_CYC = (STATE_TIMER_US * CLK_HZ + 999999) / 1000000;
  localparam longint HR_LONG_CYC    = HR_LONG_S * CLK_HZ;
  localparam longint HR_SHORT_CYC   = HR_SHORT_S * CLK_HZ;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    ST_RUN       = 5'b00001,
    ST_HR_TIMER  = 5'b00010,
    ST_FULL_RST  = 5'b00100,
    ST_SB_TIMER  = 5'b01000,
    ST_STANDBY   = 5'b10000
  } ctrl_state_t;

  typedef struct packed {
    logic       wr_strobe;
    logic       rd_strobe;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic uv_warn;
    logic uv_fault;
    logic ot_warn;
    logic ot_fault;
  } fault_in_t;

endpackage : pwr_status_pkg

//--- bench/power_status_checker.sv
module power_status_checker
  import pwr_status_pkg::*;
(
  input wire logic       ref_clk_in,                // Clock
  input wire logic       reset_n_in,                // Reset, active low
  input wire reg_req_t   reg_req_in,                // Register access
  input wire logic [7:0] reg_rdata_out,             // Read data
  input wire logic [7:0] reg_enabled_in,            // Enabled regulators
  input wire logic       button_n_in,               // Pushbutton
  input wire logic       always_alive_low_in,       // Always-alive rail low
  input wire logic       step_down1_enable_pin_in,  // Step-down 1 pin
  input wire logic       irq_n_out,                 // Interrupt
  input wire logic       power_ok_pin_oe_out,       // Power-ok pull
  input wire logic       reset_out_n,               // Reset output
  input wire logic       run_seq_down_out,          // Down sequence
  input wire logic       term_ref_en_out,           // Term ref enable
  input wire logic       step_down1_en_out,         // Step-down 1 enable
  input wire logic [7:0] aux_regulator_control_out, // Aux control
  input wire logic [1:0] state_out                  // Controller state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Any access to the clear command
  logic clr_hit;
  assign clr_hit = (reg_req_in.wr_strobe | reg_req_in.rd_strobe) &&
                   (reg_req_in.addr == REG_CLEAR_IRQ);

  a_alive_reset: assert property (always_alive_low_in |-> !reset_out_n)
    else $error("reset output high while rail low");
  a_hr_timer_reset: assert property ((state_out == 2'd0 && reg_req_in.wr_strobe &&
    reg_req_in.addr == REG_HARD_RESET) |=> (!reset_out_n)[*8])
    else $error("reset output high in hard reset timer");
  a_seq_in_timer: assert property (run_seq_down_out |-> state_out == 2'd1)
    else $error("down sequence outside standby timer");
  a_timer_length: assert property ((state_out == 2'd1 && $past(state_out) != 2'd1) |->
    (state_out == 2'd1)[*8] ##[1:4] (state_out == 2'd2 || state_out == 2'd3))
    else $error("timer state length wrong");
  a_term_pair: assert property (term_ref_en_out == step_down1_en_out)
    else $error("termination and step-down enables differ");
  a_pin_enables: assert property (step_down1_enable_pin_in |-> step_down1_en_out)
    else $error("enable pin ignored");
  a_irq_latch: assert property ((!irq_n_out && button_n_in && !clr_hit) |=> !irq_n_out)
    else $error("interrupt released without clear");
  a_status_bit7: assert property ((reg_req_in.addr == REG_IRQ_STATUS) |=> !reg_rdata_out[7])
    else $error("interrupt status bit 7 set");
  a_aux_readback: assert property ((reg_req_in.addr == REG_AUX_CONTROL &&
    !reg_req_in.wr_strobe) |=> reg_rdata_out == $past(aux_regulator_control_out))
    else $error("aux control read mismatch");
  a_none_enabled: assert property ((reg_enabled_in == 8'h00)[*3] |-> power_ok_pin_oe_out)
    else $error("power-ok pin released with nothing enabled");
endmodule : power_status_checker

bind power_status_irq_hard_reset power_status_checker chk (.ref_clk_in, .reset_n_in,
  .reg_req_in, .reg_rdata_out, .reg_enabled_in, .button_n_in, .always_alive_low_in,
  .step_down1_enable_pin_in, .irq_n_out, .power_ok_pin_oe_out, .reset_out_n,
  .run_seq_down_out, .term_ref_en_out, .step_down1_en_out, .aux_regulator_control_out,
  .state_out);

//--- bench/reg_master_model.sv
module reg_master_model
  import pwr_status_pkg::*;
(
  input  wire logic       clk_in,   // Bus clock
  input  wire logic [7:0] rdata_in, // Read data from block
  output reg_req_t        req_out   // Request to block
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial req_out = '0;

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req_out = {1'b1, 1'b0, a, d};
    @(negedge clk_in);
    req_out = {1'b0, 1'b0, ~a, ~d};
  endtask : write_reg

  // Read, address held until the answer is taken
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    req_out = {1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in);
    d = rdata_in;
    req_out = {1'b0, 1'b0, ~a, 8'hff};
  endtask : read_reg
endmodule : reg_master_model

//--- bench/power_status_irq_hard_reset_test.sv
module power_status_irq_hard_reset_test import pwr_status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 10, HS = 20, HL = 40, BC = 30, PH = 20, PP = 50;
  logic ref_clk_in = 0, reset_n_in = 0, button_n_in = 1, always_alive_low_in = 0;
  logic serial_supply_low_in = 0, step_down1_enable_pin_in = 0, seq_done_in = 0;
  logic [7:0] pg_low_in = 8'h00, reg_enabled_in = 8'h00, reg_rdata_out, d;
  logic [7:0] aux_regulator_control_out;
  fault_in_t  fault_in = '0;
  reg_req_t   reg_req_in;
  logic irq_n_out, power_ok_pin_oe_out, reset_out_n, run_seq_down_out;
  logic term_ref_en_out, step_down1_en_out;
  logic [1:0] state_out;
  int mismatches = 0, num_checks = 0, cycles = 0;

  // Clock, 8 ns period
  initial forever #4 ref_clk_in = ~ref_clk_in;

  // Block with shortened timers
  power_status_irq_hard_reset #(.PG_HOLD_CYCLES(PH), .PG_PERSIST_CYCLES(PP),
    .BUTTON_CLR_CYCLES(BC), .STATE_CYCLES(SC), .HR_LONG_CYCLES(HL), .HR_SHORT_CYCLES(HS)) dut (
    .ref_clk_in, .reset_n_in, .reg_req_in, .reg_rdata_out, .pg_low_in, .reg_enabled_in,
    .fault_in, .button_n_in, .always_alive_low_in, .serial_supply_low_in,
    .step_down1_enable_pin_in, .seq_done_in, .irq_n_out, .power_ok_pin_oe_out, .reset_out_n,
    .run_seq_down_out, .term_ref_en_out, .step_down1_en_out, .aux_regulator_control_out,
    .state_out);
  reg_master_model mst (.clk_in(ref_clk_in), .rdata_in(reg_rdata_out), .req_out(reg_req_in));

  // Cycle ceiling against hangs
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 3000) finish_test(1);
  end

  task automatic finish_test(input int extra);
    mismatches += extra;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask : chk1

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] exp);
    mst.read_reg(a, d);
    chk(what, exp, d & m);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : cyc

  task automatic clr;
    mst.read_reg(REG_CLEAR_IRQ, d);
    cyc(1);
  endtask : clr

  task automatic pulse(input fault_in_t f);
    cyc(1);
    fault_in = f;
    cyc(2);
    fault_in = '0;
  endtask : pulse

  task automatic t_defaults;
    rd("pg_mask", REG_PG_PIN_MASK, 8'hff, 8'hef);
    rd("irq_mask", REG_IRQ_PIN_MASK, 8'hff, 8'h00);
    rd("aux_ctrl", REG_AUX_CONTROL, 8'hff, 8'h00);
    rd("irq_stat", REG_IRQ_STATUS, 8'hfe, 8'h00);
    rd("unmapped", 8'h00, 8'hff, 8'h00);
    mst.write_reg(REG_PG_PIN_MASK, 8'hff);
    rd("pg_mask_rsvd", REG_PG_PIN_MASK, 8'hff, 8'hef);
    mst.write_reg(REG_IRQ_PIN_MASK, 8'hff);
    rd("irq_mask_bits", REG_IRQ_PIN_MASK, 8'hff, 8'h7d);
    mst.write_reg(REG_AUX_CONTROL, 8'hff);
    rd("aux_bits", REG_AUX_CONTROL, 8'hff, 8'h1f);
    chk("aux_out", 8'h1f, aux_regulator_control_out);
    mst.write_reg(REG_IRQ_PIN_MASK, 8'h00);
    mst.write_reg(REG_HELD_STATUS, 8'h00);
    rd("held_ro", REG_HELD_STATUS, 8'hff, 8'hff);
  endtask : t_defaults

  task automatic t_power_ok_pin;
    reg_enabled_in = 8'hff;
    pg_low_in = 8'h81;
    cyc(4);
    chk1("pok_pull", 1, power_ok_pin_oe_out);
    mst.write_reg(REG_PG_PIN_MASK, 8'h6e);
    cyc(2);
    chk1("pok_masked", 0, power_ok_pin_oe_out);
    rd("live_masked", REG_LIVE_STATUS, 8'hff, 8'h7e);
    mst.write_reg(REG_PG_PIN_MASK, 8'hef);
    cyc(PP);
    chk1("irq_pg", 0, irq_n_out);
    rd("stat_pg", REG_IRQ_STATUS, 8'h04, 8'h04);
    pg_low_in = 8'h00;
    cyc(2);
    rd("live_ok", REG_LIVE_STATUS, 8'hff, 8'hff);
    rd("held_low", REG_HELD_STATUS, 8'hff, 8'h7e);
    cyc(PH);
    rd("held_ok", REG_HELD_STATUS, 8'hff, 8'hff);
    clr();
    chk1("irq_clr", 1, irq_n_out);
    rd("stat_clr", REG_IRQ_STATUS, 8'hfe, 8'h00);
  endtask : t_power_ok_pin

  task automatic t_warn;
    fault_in_t  src[2] = '{4'h8, 4'h2};
    logic [7:0] bv[2] = '{8'h08, 8'h20};
    for (int i = 0; i < 2; i++)
    begin
      pulse(src[i]);
      chk1("irq_warn", 0, irq_n_out);
      rd("stat_warn", REG_IRQ_STATUS, 8'hfe, bv[i]);
      clr();
      mst.write_reg(REG_IRQ_PIN_MASK, bv[i]);
      pulse(src[i]);
      chk1("irq_masked", 1, irq_n_out);
      rd("stat_masked", REG_IRQ_STATUS, 8'hfe, bv[i]);
      clr();
      mst.write_reg(REG_IRQ_PIN_MASK, 8'h00);
    end
  endtask : t_warn

  task automatic t_button;
    pulse(4'h8);
    button_n_in = 0;
    cyc(2);
    rd("stat_button", REG_IRQ_STATUS, 8'h01, 8'h01);
    cyc(BC);
    chk1("irq_button", 1, irq_n_out);
    chk("state_long", 8'h00, {6'h00, state_out});
    button_n_in = 1;
    clr();
  endtask : t_button

  task automatic t_hard_cmd;
    pulse(4'h8);
    mst.write_reg(REG_HARD_RESET, 8'h00);
    cyc(1);
    chk("state_hr", 8'h01, {6'h00, state_out});
    chk1("rst_hr", 0, reset_out_n);
    cyc(SC + 2);
    chk1("hr_done", 1, state_out != 2'd1);
    chk("aux_dflt", 8'h00, aux_regulator_control_out);
    chk1("irq_kept", 0, irq_n_out);
    rd("stat_kept", REG_IRQ_STATUS, 8'h0a, 8'h0a);
    clr();
  endtask : t_hard_cmd

  task automatic t_hard_button;
    mst.write_reg(REG_CONTROL, 8'h40);
    button_n_in = 0;
    cyc(HS + 3);
    chk("state_btn", 8'h01, {6'h00, state_out});
    button_n_in = 1;
    cyc(SC + 2);
    rd("ctrl_dflt", REG_CONTROL, 8'hff, 8'h00);
    clr();
  endtask : t_hard_button

  task automatic t_misc;
    step_down1_enable_pin_in = 1;
    cyc(1);
    chk1("term_pin", 1, term_ref_en_out);
    step_down1_enable_pin_in = 0;
    cyc(1);
    chk1("sd1_off", 0, step_down1_en_out);
    mst.write_reg(REG_STEP_DOWN1, 8'h80);
    cyc(1);
    chk1("term_bit", 1, term_ref_en_out);
    mst.write_reg(REG_PG_PIN_MASK, 8'h00);
    serial_supply_low_in = 1;
    cyc(2);
    serial_supply_low_in = 0;
    cyc(1);
    chk1("sd1_dflt", 0, step_down1_en_out);
    rd("pg_mask_dflt", REG_PG_PIN_MASK, 8'hff, 8'hef);
    always_alive_low_in = 1;
    cyc(1);
    chk1("rst_alive", 0, reset_out_n);
    always_alive_low_in = 0;
  endtask : t_misc

  task automatic t_fault;
    mst.write_reg(REG_IRQ_PIN_MASK, 8'h40);
    cyc(1);
    fault_in = 4'h1;
    cyc(2);
    chk("state_sb", 8'h01, {6'h00, state_out});
    chk1("seq_run", 1, run_seq_down_out);
    chk1("irq_fault", 1, irq_n_out);
    seq_done_in = 1;
    cyc(SC + 2);
    chk("state_stby", 8'h03, {6'h00, state_out});
    rd("stat_ot", REG_IRQ_STATUS, 8'h40, 8'h40);
    fault_in = '0;
    cyc(2);
    chk("state_back", 8'h00, {6'h00, state_out});
  endtask : t_fault

  // Reset, then scenarios in turn
  initial
  begin
    cyc(16);
    reset_n_in = 1;
    cyc(2);
    t_defaults();
    t_power_ok_pin();
    t_warn();
    t_button();
    t_hard_cmd();
    t_hard_button();
    t_misc();
    t_fault();
    finish_test(0);
  end
endmodule : power_status_irq_hard_reset_test
